// ### src/oafc_pkg.sv
// constants, carriers and helpers for the operand address and fetch control
// assumes one 125 MHz clock and a destructive-read core memory outside
package oafc_pkg;
  // ****************************************
  // word layout and timing
  // ****************************************
  localparam int WORD_W = 24;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 15;
  localparam int OP_LSB = 18;
  localparam int SEL_LSB = 15;
  localparam int FLD_LSB = 12;
  localparam logic [5:0] OP_SPC_A = 6'h01;
  localparam logic [5:0] OP_SPC_B = 6'h03;
  localparam logic [5:0] OP_SPC_C = 6'h05;
  localparam logic [5:0] OP_SPC_D = 6'h06;
  // octal 13: store accumulator through the operand register
  localparam logic [5:0] OP_STORE_ACC = 6'h0b;
  localparam logic [1:0] OP_READ_GRP = 2'h1;
  localparam int CLK_NS = 8;
  localparam int CORE_CYCLE_NS = 2000;
  localparam int REWRITE_CYC = CORE_CYCLE_NS / CLK_NS;
  localparam logic [3:0] LDX_ARM_T = 4'h8;
  localparam logic [3:0] LDX_XFER_T = 4'ha;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_OPERAND = 12'h008;
  localparam logic [11:0] A_INSTR = 12'h00c;
  localparam logic [11:0] A_SADDR = 12'h010;
  localparam logic [6:0] A_IDX_BLK = 7'h01;
  localparam int CTRL_LDX = 0;
  localparam int STS_M_LSB = 8;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } oafc_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } oafc_apb_rsp_t;
  typedef struct packed {
    logic start;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } oafc_mem_req_t;
  typedef struct packed {
    logic special;
    logic rd;
    logic wr;
    logic acc_to_x;
  } oafc_flags_t;
  typedef enum logic [1:0] {S_IDLE, S_DECODE, S_RETRANS, S_CHAIN} oafc_dec_t;
  typedef enum logic [2:0] {M_IDLE, M_RD_PROBE, M_RD_REWR, M_RD_XFER, M_WR_PROBE,
                            M_WR_REWR} oafc_mem_t;
  typedef struct packed {
    oafc_dec_t st;
    oafc_mem_t mph;
    oafc_flags_t flags;
    logic [WORD_W-1:0] ir;
    logic [2:0] fld;
    logic add_pend;
    logic rd_pend;
    logic wr_pend;
    logic buf_to_x;
    logic resume;
    logic ldx_busy;
    logic ldx_armed;
    logic [3:0] ldx_cnt;
    logic [7:0] rw_cnt;
    logic [ADDR_W-1:0] sar;
    logic [WORD_W-1:0] mbuf;
    logic [WORD_W-1:0] x;
    logic [7:0][IDX_W-1:0] idx;
    logic special_p;
    logic acc_to_x_p;
    oafc_mem_req_t mem;
    oafc_apb_rsp_t rsp;
  } oafc_state_t;
  // ****************************************
  // helpers
  // ****************************************
  function automatic oafc_flags_t oafc_decode(input logic [5:0] op);
    oafc_flags_t f;
    f = '0;
    f.special = (op == OP_SPC_A) || (op == OP_SPC_B) || (op == OP_SPC_C) || (op == OP_SPC_D);
    f.wr = (op == OP_STORE_ACC);
    f.acc_to_x = (op == OP_STORE_ACC);
    f.rd = (op[5:4] == OP_READ_GRP) && (op != OP_STORE_ACC);
    return f;
  endfunction
  function automatic logic [23:0] oafc_extract(input logic [23:0] w, input logic [2:0] m);
    logic [23:0] r;
    case (m)
      3'h0: r = w;
      3'h1: r = {{16{w[7]}}, w[7:0]};
      3'h2: r = {{16{w[15]}}, w[15:8]};
      3'h3: r = {{16{w[23]}}, w[23:16]};
      3'h4: r = {9'h000, w[14:0]};
      3'h5: r = {16'h0000, w[7:0]};
      3'h6: r = {16'h0000, w[15:8]};
      default: r = {16'h0000, w[23:16]};
    endcase
    return r;
  endfunction
  function automatic logic [23:0] oafc_merge(input logic [23:0] old, input logic [23:0] x,
                                             input logic [2:0] m);
    logic [23:0] r;
    case (m)
      3'h0: r = x;
      3'h1, 3'h5: r = {old[23:8], x[7:0]};
      3'h2, 3'h6: r = {old[23:16], x[7:0], old[7:0]};
      3'h3, 3'h7: r = {x[7:0], old[15:0]};
      default: r = {old[23:15], x[14:0]};
    endcase
    return r;
  endfunction
endpackage

// ### src/oafc_top.sv
// instruction decode, index add, storage address and operand read/write control
// assumes a core memory that answers a start with a read probe and rdata,
// and that command and instruction step pulses are one cycle wide
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ns
module oafc_top #(
  parameter int REWRITE_CYC_P = oafc_pkg::REWRITE_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register bus
  input wire oafc_pkg::oafc_apb_req_t apb_req_in,
  output oafc_pkg::oafc_apb_rsp_t apb_rsp_out,
  // sequencing pulses and instruction load
  input wire logic cmd_step_in,
  input wire logic instr_step_in,
  input wire logic instr_load_in,
  input wire logic [23:0] instr_in,
  // other address sources
  input wire logic pc_load_in,
  input wire logic [11:0] pc_in,
  input wire logic manual_load_in,
  input wire logic [11:0] manual_addr_in,
  // core memory
  input wire logic mem_ready_in,
  input wire logic mem_probe_in,
  input wire logic [23:0] mem_rdata_in,
  output oafc_pkg::oafc_mem_req_t mem_req_out,
  // sequence outputs
  output logic special_path_out,
  output logic acc_to_x_out,
  output logic [23:0] operand_out
);
  import oafc_pkg::*;

  if (REWRITE_CYC_P < 1 || REWRITE_CYC_P > 255) begin : g_bad_rewrite
    $error("REWRITE_CYC_P must lie in 1..255");
  end

  localparam logic [7:0] RW_LAST = 8'(REWRITE_CYC_P - 1);

  oafc_state_t s;
  oafc_state_t n;
  logic hit;
  logic [2:0] isel;
  logic [31:0] rd_word;
  logic [11:0] pa;

  assign pa = apb_req_in.paddr;
  assign isel = pa[4:2];

  // ****************************************
  // register read mux and decode
  // ****************************************
  always_comb begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    if (pa == A_CTRL) begin
      rd_word = {31'h0000_0000, s.ldx_busy};
    end else if (pa == A_STATUS) begin
      rd_word = {21'h00_0000, s.fld, s.resume, s.buf_to_x, s.wr_pend, s.rd_pend,
                 s.add_pend, s.ldx_armed, s.ldx_busy, 1'b0};
      rd_word[STS_M_LSB-1] = (s.mph != M_IDLE);
    end else if (pa == A_OPERAND) begin
      rd_word = {8'h00, s.x};
    end else if (pa == A_INSTR) begin
      rd_word = {8'h00, s.ir};
    end else if (pa == A_SADDR) begin
      rd_word = {20'h0_0000, s.sar};
    end else if (pa[11:5] == A_IDX_BLK && pa[1:0] == 2'h0 && isel != 3'h0) begin
      rd_word = {17'h0_0000, s.idx[isel]};
    end else begin
      hit = 1'b0;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = s;
    n.special_p = 1'b0;
    n.acc_to_x_p = 1'b0;
    n.mem.start = 1'b0;
    n.mem.write = 1'b0;
    n.rsp.pready = 1'b1;
    // bus: read data and error prepared in setup, held through access
    if (apb_req_in.psel && !apb_req_in.penable) begin
      n.rsp.prdata = rd_word;
      n.rsp.pslverr = !hit;
    end
    if (apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && hit) begin
      if (pa == A_CTRL && apb_req_in.pwdata[CTRL_LDX] && !s.ldx_busy) begin
        n.ldx_busy = 1'b1;
        n.ldx_cnt = 4'h0;
      end else if (pa == A_OPERAND) begin
        n.x = apb_req_in.pwdata[23:0];
      end else if (pa[11:5] == A_IDX_BLK) begin
        n.idx[isel] = apb_req_in.pwdata[14:0];
      end
    end
    // decode and address modification chain
    case (s.st)
      S_IDLE: begin
        if (instr_load_in) begin
          n.ir = instr_in;
          n.flags = oafc_decode(instr_in[OP_LSB +: 6]);
          n.fld = instr_in[FLD_LSB +: 3];
          n.add_pend = 1'b1;
          n.st = S_DECODE;
        end
      end
      S_DECODE: begin
        if (instr_step_in) begin
          n.add_pend = 1'b0;
          if (s.flags.special) begin
            n.special_p = 1'b1;
            n.st = S_IDLE;
          end else begin
            // index 0 is held at zero, so selector 0 means no modification
            n.ir[IDX_W-1:0] = s.ir[IDX_W-1:0] + s.idx[s.ir[SEL_LSB +: 3]];
            n.st = S_RETRANS;
          end
        end
      end
      S_RETRANS: begin
        n.fld = s.ir[FLD_LSB +: 3];
        n.st = S_CHAIN;
      end
      S_CHAIN: begin
        if (instr_step_in) begin
          n.wr_pend = s.wr_pend | s.flags.wr;
          n.acc_to_x_p = s.flags.acc_to_x;
          n.rd_pend = s.rd_pend | s.flags.rd;
          n.st = S_IDLE;
        end
      end
      default: n.st = S_IDLE;
    endcase
    // index load from the instruction, timed by instruction steps
    if (s.ldx_busy && instr_step_in) begin
      n.ldx_cnt = s.ldx_cnt + 4'h1;
      if (n.ldx_cnt == LDX_ARM_T) begin
        n.ldx_armed = 1'b1;
      end
      if (n.ldx_cnt == LDX_XFER_T && s.ldx_armed) begin
        if (s.ir[SEL_LSB +: 3] != 3'h0) begin
          n.idx[s.ir[SEL_LSB +: 3]] = s.ir[IDX_W-1:0];
        end
        n.ldx_armed = 1'b0;
        n.ldx_busy = 1'b0;
      end
    end
    // memory sequences; a single phase register keeps cycles apart
    case (s.mph)
      M_IDLE: begin
        if (cmd_step_in && s.resume && (s.rd_pend || s.wr_pend)) begin
          n.resume = 1'b0;
          n.sar = '0;
          n.sar = s.ir[ADDR_W-1:0];
          n.mem.start = 1'b1;
          n.mem.addr = n.sar;
          if (s.rd_pend) begin
            // a request raised by the chain in this very cycle is kept
            n.rd_pend = (s.st == S_CHAIN) && instr_step_in && s.flags.rd;
            n.mbuf = '0;
            n.buf_to_x = 1'b1;
            n.mph = M_RD_PROBE;
          end else begin
            n.wr_pend = (s.st == S_CHAIN) && instr_step_in && s.flags.wr;
            n.mph = M_WR_PROBE;
          end
        end else if (pc_load_in) begin
          n.sar = pc_in;
          n.mem.addr = pc_in;
        end else if (manual_load_in) begin
          n.sar = manual_addr_in;
          n.mem.addr = manual_addr_in;
        end
      end
      M_RD_PROBE, M_WR_PROBE: begin
        if (mem_probe_in) begin
          n.rw_cnt = 8'h00;
          if (s.mph == M_RD_PROBE) begin
            n.mbuf = mem_rdata_in;
            n.mph = M_RD_REWR;
          end else begin
            n.mbuf = oafc_merge(mem_rdata_in, s.x, s.fld);
            n.mph = M_WR_REWR;
          end
        end
      end
      M_RD_REWR, M_WR_REWR: begin
        n.rw_cnt = s.rw_cnt + 8'h01;
        if (s.rw_cnt == RW_LAST) begin
          n.mem.write = 1'b1;
          n.mem.wdata = s.mbuf;
          n.mph = (s.mph == M_RD_REWR) ? M_RD_XFER : M_IDLE;
        end
      end
      M_RD_XFER: begin
        if (cmd_step_in) begin
          n.buf_to_x = 1'b0;
          n.x = oafc_extract(s.mbuf, s.fld);
          n.mph = M_IDLE;
        end
      end
      default: n.mph = M_IDLE;
    endcase
    // ready seen in the same cycle as the clear is kept
    if (mem_ready_in) begin
      n.resume = 1'b1;
    end
    n.idx[0] = '0;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign apb_rsp_out = s.rsp;
  assign mem_req_out = s.mem;
  assign special_path_out = s.special_p;
  assign acc_to_x_out = s.acc_to_x_p;
  assign operand_out = s.x;

  // ****************************************
  // checks
  // ****************************************
  localparam int RW_D = REWRITE_CYC_P + 1;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_read_start_gate: assert property (mem_req_out.start |-> $past(cmd_step_in) && $past(s.resume))
    else $error("memory cycle started without step and ready");
  a_sar_from_instr: assert property (mem_req_out.start |-> mem_req_out.addr == $past(s.ir[11:0]))
    else $error("storage address not taken from instruction");
  a_rewrite_delay: assert property ((s.mph == M_RD_PROBE && mem_probe_in) |-> ##RW_D mem_req_out.write)
    else $error("rewrite not issued one core cycle after read");
  a_single_cycle: assert property (mem_req_out.start |=> (!mem_req_out.start)[*3])
    else $error("second memory cycle started too soon");
  a_pend_held: assert property ((s.rd_pend && !s.resume) |=> s.rd_pend)
    else $error("read request dropped before memory ready");
  a_field_xfer: assert property ((s.mph == M_RD_XFER && cmd_step_in) |=>
      operand_out == oafc_extract($past(s.mbuf), $past(s.fld)) && !s.buf_to_x)
    else $error("operand field transfer wrong");
  a_write_merge: assert property ((s.mph == M_WR_PROBE && mem_probe_in) |=>
      s.mbuf == oafc_merge($past(mem_rdata_in), $past(s.x), $past(s.fld)))
    else $error("write merge wrong");
  a_index_add: assert property ((s.st == S_DECODE && instr_step_in && !s.flags.special) |=>
      s.ir[14:0] == 15'($past(s.ir[14:0]) + $past(s.idx[s.ir[17:15]])))
    else $error("index not added to instruction");
  a_special_skip: assert property ((s.st == S_DECODE && instr_step_in && s.flags.special) |=>
      special_path_out && s.ir == $past(s.ir) && !s.add_pend)
    else $error("special code modified or not branched");
  a_retranslate: assert property (s.st == S_RETRANS |=> s.fld == $past(s.ir[14:12]))
    else $error("field selector not retranslated");

  c_read_done: cover property (s.mph == M_RD_XFER && cmd_step_in);
  c_write_done: cover property (s.mph == M_WR_REWR ##1 s.mph == M_IDLE);
  c_special: cover property (special_path_out);
  c_index_load: cover property (s.ldx_armed ##1 !s.ldx_busy);
endmodule

// ### sim/oafc_core_model.sv
// core memory model for the operand fetch bench
// assumes start opens a cycle at addr and write closes it at addr
`timescale 1ns/1ns
module oafc_core_model #(
  parameter int PROBE_DLY = 3
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // controller side
  input wire oafc_pkg::oafc_mem_req_t mem_req_in,
  output logic mem_ready_out,
  output logic mem_probe_out,
  output logic [23:0] mem_rdata_out
);
  import oafc_pkg::*;
  logic [23:0] mem [0:4095];
  logic [11:0] a;
  int cnt;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_ready_out <= 1'b1;
      mem_probe_out <= 1'b0;
      mem_rdata_out <= 24'h000000;
      cnt <= 0;
    end else begin
      mem_probe_out <= 1'b0;
      // released lines toggle, so a stale word never looks valid
      mem_rdata_out <= ~mem_rdata_out;
      if (mem_req_in.start) begin
        mem_ready_out <= 1'b0;
        a <= mem_req_in.addr;
        cnt <= PROBE_DLY;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        mem_probe_out <= 1'b1;
        mem_rdata_out <= mem[a];
        mem[a] <= 24'h000000;
      end
      if (mem_req_in.write) begin
        mem[mem_req_in.addr] <= mem_req_in.wdata;
        mem_ready_out <= 1'b1;
      end
    end
  end
endmodule

// ### sim/testbench.sv
// self-checking bench for the operand address and fetch control
// assumes the core memory model beside it and a short rewrite count
`timescale 1ns/1ns
module testbench;
  import oafc_pkg::*;
  logic clk_in, rst_n_in, cmd_step, instr_step, instr_load, pc_load, man_load;
  logic mem_ready, mem_probe, spc, accx;
  logic [23:0] instr, mem_rdata, operand;
  logic [11:0] pc, man_addr;
  oafc_apb_req_t apb_req;
  oafc_apb_rsp_t apb_rsp;
  oafc_mem_req_t mem_req;
  int mismatches, checked, spc_n, acc_n;
  oafc_top #(.REWRITE_CYC_P(4)) i_oafc_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .apb_req_in(apb_req), .apb_rsp_out(apb_rsp), .cmd_step_in(cmd_step),
    .instr_step_in(instr_step), .instr_load_in(instr_load), .instr_in(instr),
    .pc_load_in(pc_load), .pc_in(pc), .manual_load_in(man_load),
    .manual_addr_in(man_addr), .mem_ready_in(mem_ready), .mem_probe_in(mem_probe),
    .mem_rdata_in(mem_rdata), .mem_req_out(mem_req), .special_path_out(spc),
    .acc_to_x_out(accx), .operand_out(operand));
  oafc_core_model #(.PROBE_DLY(3)) i_oafc_core_model (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .mem_req_in(mem_req), .mem_ready_out(mem_ready),
    .mem_probe_out(mem_probe), .mem_rdata_out(mem_rdata));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (spc === 1'b1) spc_n++;
    if (accx === 1'b1) acc_n++;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic fail(input string m);
    mismatches++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_word(input logic [23:0] g, input logic [23:0] e, input string m);
    checked++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_bus(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_cnt(input int g, input int e, input string m);
    checked++;
    if (g != e) fail(m);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_in);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_in);
    apb_req.penable <= 1'b1;
    @(posedge clk_in);
    while (apb_rsp.pready !== 1'b1 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic pulse(input int k);
    @(posedge clk_in);
    case (k)
      0: cmd_step <= 1'b1;
      1: instr_step <= 1'b1;
      2: instr_load <= 1'b1;
      3: pc_load <= 1'b1;
      default: man_load <= 1'b1;
    endcase
    @(posedge clk_in);
    {cmd_step, instr_step, instr_load, pc_load, man_load} <= 5'h00;
  endtask
  task automatic run_instr(input logic [23:0] i);
    spc_n = 0;
    acc_n = 0;
    instr <= i;
    pulse(2);
    repeat (3) begin
      repeat (2) @(posedge clk_in);
      pulse(1);
    end
  endtask
  task automatic mem_cycle(output logic [11:0] a, output logic [23:0] wd);
    int n;
    n = 0;
    a = 12'hfff;
    pulse(0);
    while (n < 100) begin
      @(posedge clk_in);
      n++;
      if (mem_req.start === 1'b1) a = mem_req.addr;
      if (mem_req.write === 1'b1) break;
    end
    wd = mem_req.wdata;
    if (n >= 100) fail("no rewrite pulse");
  endtask
  function automatic logic [23:0] fld(input logic [23:0] w, input int m);
    logic [7:0] b;
    if (m == 0) return w;
    if (m == 4) return {9'h000, w[14:0]};
    b = w[8*((m-1)%4) +: 8];
    return (m < 4) ? {{16{b[7]}}, b} : {16'h0000, b};
  endfunction
  task automatic rd_op(input logic [23:0] i, input logic [11:0] ea, input logic [23:0] w,
                       input logic [23:0] e);
    logic [11:0] a;
    logic [23:0] wd;
    i_oafc_core_model.mem[ea] = w;
    run_instr(i);
    mem_cycle(a, wd);
    chk_word({12'h000, a}, {12'h000, ea}, "read address");
    chk_word(wd, w, "rewrite word");
    pulse(0);
    repeat (3) @(posedge clk_in);
    chk_word(operand, e, "operand field");
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    apb(1'b0, A_OPERAND, 32'h0, q, e);
    chk_bus(q, 32'h0, "operand after reset");
    apb(1'b0, 12'h020, 32'h0, q, e);
    chk_bus({31'h0, e}, 32'h1, "unmapped slot not refused");
    apb(1'b1, 12'h024, 32'h1, q, e);
    apb(1'b0, 12'h024, 32'h0, q, e);
    chk_bus(q, 32'h1, "index one readback");
    $display("registers done");
  endtask
  task automatic t_addr();
    pc <= 12'h5a3;
    pulse(3);
    repeat (2) @(posedge clk_in);
    chk_word({12'h000, mem_req.addr}, 24'h0005a3, "counter address");
    man_addr <= 12'h3c5;
    pulse(4);
    repeat (2) @(posedge clk_in);
    chk_word({12'h000, mem_req.addr}, 24'h0003c5, "manual address");
    $display("address sources done");
  endtask
  task automatic t_fields();
    logic [2:0] mm;
    for (int m = 0; m < 8; m++) begin
      mm = m[2:0];
      rd_op({6'h10, 3'h0, mm, 9'h020, mm}, {9'h020, mm}, 24'ha5bc7e,
            fld(24'ha5bc7e, m));
    end
    $display("field selectors done");
  endtask
  task automatic t_retrans();
    // carry out of the address changes the field selector from 0 to 1
    rd_op({6'h10, 3'h1, 3'h0, 12'hfff}, 12'h000, 24'h000080, 24'hffff80);
    $display("index add done");
  endtask
  task automatic t_write();
    logic [31:0] q;
    logic e;
    logic [11:0] a;
    logic [23:0] wd;
    apb(1'b1, A_OPERAND, 32'h005566ab, q, e);
    i_oafc_core_model.mem[12'h123] = 24'h112233;
    run_instr({6'h0b, 3'h0, 3'h2, 12'h123});
    chk_cnt(acc_n, 1, "accumulator sequence pulse");
    mem_cycle(a, wd);
    chk_word({12'h000, a}, 24'h000123, "write address");
    chk_word(wd, 24'h11ab33, "merged word");
    $display("write merge done");
  endtask
  task automatic t_special();
    logic [5:0] ops [4];
    ops = '{6'h01, 6'h03, 6'h05, 6'h06};
    foreach (ops[k]) begin
      run_instr({ops[k], 3'h2, 15'h0000});
      chk_cnt(spc_n, 1, "special branch pulse");
    end
    $display("special codes done");
  endtask
  task automatic t_ldx();
    logic [31:0] q;
    logic e;
    run_instr({6'h01, 3'h3, 15'h1234});
    apb(1'b1, A_CTRL, 32'h1, q, e);
    repeat (9) pulse(1);
    apb(1'b0, 12'h02c, 32'h0, q, e);
    chk_bus(q, 32'h0, "index moved early");
    pulse(1);
    apb(1'b0, 12'h02c, 32'h0, q, e);
    chk_bus(q, 32'h1234, "index load value");
    $display("index load done");
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst_n_in = 1'b0;
    apb_req = '0;
    {cmd_step, instr_step, instr_load, pc_load, man_load} = 5'h00;
    instr = 24'h000000;
    pc = 12'h000;
    man_addr = 12'h000;
    mismatches = 0;
    checked = 0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_addr();
    t_fields();
    t_retrans();
    t_write();
    t_special();
    t_ldx();
    summarize();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    fail("watchdog expired");
    summarize();
  end
endmodule
